// [mcas_top.sv]
// Notes on behaviour
// - Request from pin or software bit.
// - Pin and software bit are ORed.
// - Combined request retimed through flip-flop chain.
// - Retimed request resampled on feedback divider.
// - Rising request starts initialization, then holds.
// - Enabled divider runs until fall, freezes low.
// - Feed trailing devices, then freeze own outputs.
// - Falling request starts completion.
// - Arm trailing devices, sync dividers, resume.
// - Trailing role skips seven edges, resumes eighth.
// - Three modes: disabled, drive, align.
// - Disabled outputs keep toggling throughout.
// - Each output has its own enable bit.
// - Drive outputs have own divide ratio.
// - Align outputs match trailing-device outputs.
// - Per-output cycle delay applied at restart.
// - No runt pulses when gating.
// - Role bit picks mode, auto delay.
`timescale 1ns/1ns
`default_nettype none

module mcas_top #(
  parameter int N_OUT = 4,
  parameter int SYNC_STAGES = 2,
  parameter bit HAS_PLL = 1'b1,
  parameter int FB_DIV = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request pin
  input wire logic shared_align_request_pin,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Divided clock outputs
  output logic [N_OUT-1:0] clk_out
);

  // ----------------------------------------------------------------------
  // Register decode helpers
  // ----------------------------------------------------------------------
  function automatic logic is_ocfg(input logic [7:0] ofs);
    logic [7:0] top;
    top = mcas_pkg::OCFG_BASE_OFS + 8'(N_OUT * 4);
    return (ofs >= mcas_pkg::OCFG_BASE_OFS) && (ofs < top) && (ofs[1:0] == 2'b00);
  endfunction

  function automatic logic [7:0] ocfg_idx(input logic [7:0] ofs);
    logic [7:0] rel;
    rel = ofs - mcas_pkg::OCFG_BASE_OFS;
    return rel >> 2;
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------------
  logic pend_r;
  logic pend_wr_r;
  logic [7:0] pend_ofs_r;
  logic sw_align_r;
  logic trail_role_r;
  logic auto_dly_r;
  mcas_pkg::mcas_ocfg_t ocfg_r [N_OUT];
  logic addr_ok;
  logic wr_now;

  // Every transfer gets one wait state so that read data comes from a flop.
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_now = pend_r && pend_wr_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_ofs_r <= 8'h00;
    end else if (addr_ok) begin
      pend_r <= 1'b1;
      pend_wr_r <= hwrite && (hsize == 3'h2);
      pend_ofs_r <= haddr[7:0];
    end else begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !addr_ok;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sw_align_r <= mcas_pkg::CTRL_RST[mcas_pkg::CTRL_SW_BIT];
      trail_role_r <= mcas_pkg::CTRL_RST[mcas_pkg::CTRL_TRAIL_BIT];
      auto_dly_r <= mcas_pkg::CTRL_RST[mcas_pkg::CTRL_AUTO_BIT];
    end else if (wr_now && pend_ofs_r == mcas_pkg::CTRL_OFS) begin
      sw_align_r <= hwdata[mcas_pkg::CTRL_SW_BIT];
      trail_role_r <= hwdata[mcas_pkg::CTRL_TRAIL_BIT];
      auto_dly_r <= hwdata[mcas_pkg::CTRL_AUTO_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Per-output configuration registers
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (!rstn) begin
          ocfg_r[gi].div <= mcas_pkg::DIV_RST;
          ocfg_r[gi].dly <= 12'h000;
          ocfg_r[gi].en <= 1'b0;
          ocfg_r[gi].role <= 1'b0;
        end else if (wr_now && is_ocfg(pend_ofs_r) && ocfg_idx(pend_ofs_r) == 8'(gi)) begin
          ocfg_r[gi].div <= hwdata[mcas_pkg::OCFG_DIV_LSB +: mcas_pkg::DIV_W];
          ocfg_r[gi].dly <= hwdata[mcas_pkg::OCFG_DLY_LSB +: mcas_pkg::DLY_W];
          ocfg_r[gi].en <= hwdata[mcas_pkg::OCFG_EN_BIT];
          ocfg_r[gi].role <= hwdata[mcas_pkg::OCFG_ROLE_BIT];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Request combining and retiming
  // ----------------------------------------------------------------------
  localparam int STG = (SYNC_STAGES < 2) ? 2 : SYNC_STAGES;

  logic req_comb;
  logic [STG-1:0] req_sync_r;
  logic [7:0] fb_cnt_r;
  logic fb_tick;
  logic req_fb_r;
  logic req_prev_r;
  logic req_rise;

  // The pin is taken as synchronous, but the chain stays so the pin may be
  // driven from a foreign clock without changing the sequence timing.
  assign req_comb = shared_align_request_pin | sw_align_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_sync_r <= '0;
    end else begin
      req_sync_r <= {req_sync_r[STG-2:0], req_comb};
    end
  end

  // Feedback divider tick that paces the final resample.
  assign fb_tick = (fb_cnt_r == 8'(FB_DIV - 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fb_cnt_r <= 8'h00;
    end else if (fb_tick) begin
      fb_cnt_r <= 8'h00;
    end else begin
      fb_cnt_r <= fb_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_fb_r <= 1'b0;
    end else if (!HAS_PLL || fb_tick) begin
      req_fb_r <= req_sync_r[STG-1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_prev_r <= 1'b0;
    end else begin
      req_prev_r <= req_fb_r;
    end
  end

  assign req_rise = req_fb_r && !req_prev_r;

  // ----------------------------------------------------------------------
  // Delay selection
  // ----------------------------------------------------------------------
  logic [mcas_pkg::DIV_W-1:0] drv_max;
  logic [mcas_pkg::DLY_W-1:0] eff_dly [N_OUT];

  always_comb begin
    drv_max = 8'h00;
    for (int i = 0; i < N_OUT; i++) begin
      if (ocfg_r[i].en && ocfg_r[i].role && ocfg_r[i].div > drv_max) begin
        drv_max = ocfg_r[i].div;
      end
    end
  end

  // Automatic delay keeps drive outputs on the slowest drive output and
  // shifts align outputs past the trailing devices' propagation.
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_dly
      always_comb begin
        if (!auto_dly_r) begin
          eff_dly[gi] = ocfg_r[gi].dly;
        end else if (ocfg_r[gi].role) begin
          eff_dly[gi] = 12'((drv_max - ocfg_r[gi].div) * mcas_pkg::TRAIL_MULT);
        end else begin
          eff_dly[gi] = 12'(drv_max * mcas_pkg::TRAIL_MULT);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  mcas_pkg::mcas_state_t state_r;
  logic [mcas_pkg::CNT_W-1:0] cnt_r;
  logic [N_OUT-1:0] en_mask;
  logic [N_OUT-1:0] frozen;
  logic all_frozen;
  logic freeze_req;
  logic restart;

  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_mask
      assign en_mask[gi] = ocfg_r[gi].en;
    end
  endgenerate

  assign all_frozen = &(frozen | ~en_mask);
  assign freeze_req = (state_r == mcas_pkg::ST_FREEZE);
  assign restart = (state_r == mcas_pkg::ST_LAUNCH);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= mcas_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        mcas_pkg::ST_IDLE: begin
          if (req_rise) begin
            // A trailing-role device has nothing downstream to feed.
            state_r <= trail_role_r ? mcas_pkg::ST_FREEZE : mcas_pkg::ST_FEED;
          end
        end
        mcas_pkg::ST_FEED: begin
          if (cnt_r == 16'(mcas_pkg::FEED_CYC - 1)) begin
            state_r <= mcas_pkg::ST_FREEZE;
          end
        end
        mcas_pkg::ST_FREEZE: begin
          if (all_frozen) begin
            state_r <= mcas_pkg::ST_HELD;
          end
        end
        mcas_pkg::ST_HELD: begin
          // Completion only follows a finished initialization; a request
          // dropped early is acted on once every enabled output is low.
          if (!req_fb_r) begin
            state_r <= mcas_pkg::ST_ARM;
          end
        end
        mcas_pkg::ST_ARM: begin
          if (trail_role_r && cnt_r == 16'(mcas_pkg::TRAIL_SKIP - 1)) begin
            state_r <= mcas_pkg::ST_LAUNCH;
          end else if (!trail_role_r && cnt_r == 16'(mcas_pkg::ARM_CYC - 1)) begin
            state_r <= mcas_pkg::ST_LAUNCH;
          end
        end
        mcas_pkg::ST_LAUNCH: begin
          state_r <= mcas_pkg::ST_IDLE;
        end
        default: begin
          state_r <= mcas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
    end else if (state_r == mcas_pkg::ST_FEED || state_r == mcas_pkg::ST_ARM) begin
      cnt_r <= cnt_r + 16'h0001;
    end else begin
      cnt_r <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Output dividers
  // ----------------------------------------------------------------------
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_out
      mcas_out_div u_div (
        .clk(clk),
        .rstn(rstn),
        .cfg(ocfg_r[gi]),
        .eff_dly(eff_dly[gi]),
        .freeze_req(freeze_req && ocfg_r[gi].en),
        .restart(restart && ocfg_r[gi].en),
        .clk_out(clk_out[gi]),
        .frozen(frozen[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (pend_ofs_r == mcas_pkg::CTRL_OFS) begin
      rd_val[mcas_pkg::CTRL_SW_BIT] = sw_align_r;
      rd_val[mcas_pkg::CTRL_TRAIL_BIT] = trail_role_r;
      rd_val[mcas_pkg::CTRL_AUTO_BIT] = auto_dly_r;
    end else if (pend_ofs_r == mcas_pkg::STAT_OFS) begin
      rd_val[2:0] = state_r;
      rd_val[mcas_pkg::STAT_REQ_BIT] = req_fb_r;
      rd_val[mcas_pkg::STAT_FRZ_LSB +: N_OUT] = frozen;
    end else if (is_ocfg(pend_ofs_r)) begin
      for (int i = 0; i < N_OUT; i++) begin
        if (ocfg_idx(pend_ofs_r) == 8'(i)) begin
          rd_val[mcas_pkg::OCFG_DIV_LSB +: mcas_pkg::DIV_W] = ocfg_r[i].div;
          rd_val[mcas_pkg::OCFG_DLY_LSB +: mcas_pkg::DLY_W] = ocfg_r[i].dly;
          rd_val[mcas_pkg::OCFG_EN_BIT] = ocfg_r[i].en;
          rd_val[mcas_pkg::OCFG_ROLE_BIT] = ocfg_r[i].role;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (pend_r && !pend_wr_r) begin
      hrdata <= rd_val;
    end
  end

endmodule // mcas_top

`default_nettype wire

// [mcas_pkg.sv]
package mcas_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] OCFG_BASE_OFS = 8'h10;

  // Control word fields.
  localparam int CTRL_SW_BIT = 0;
  localparam int CTRL_TRAIL_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Per-output configuration word fields.
  localparam int DIV_W = 8;
  localparam int DLY_W = 12;
  localparam int OCFG_DIV_LSB = 0;
  localparam int OCFG_DLY_LSB = 8;
  localparam int OCFG_EN_BIT = 24;
  localparam int OCFG_ROLE_BIT = 25;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h04;
  localparam logic [DIV_W-1:0] DIV_MIN = 8'h02;

  // Status word fields.
  localparam int STAT_REQ_BIT = 3;
  localparam int STAT_FRZ_LSB = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int FEED_TIME_NS = 2000;
  localparam int FEED_CYC = (FEED_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ARM_TIME_NS = 500;
  localparam int ARM_CYC = (ARM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRAIL_SKIP = 7;
  localparam int TRAIL_MULT = 7;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FEED = 3'h1,
    ST_FREEZE = 3'h3,
    ST_HELD = 3'h2,
    ST_ARM = 3'h6,
    ST_LAUNCH = 3'h7
  } mcas_state_t;

  typedef struct packed {
    logic role;
    logic en;
    logic [DLY_W-1:0] dly;
    logic [DIV_W-1:0] div;
  } mcas_ocfg_t;

endpackage

// [mcas_out_div.sv]
`timescale 1ns/1ns
`default_nettype none

module mcas_out_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire mcas_pkg::mcas_ocfg_t cfg,
  input wire logic [mcas_pkg::DLY_W-1:0] eff_dly,
  input wire logic freeze_req,
  input wire logic restart,
  // Output
  output logic clk_out,
  output logic frozen
);

  logic [mcas_pkg::DIV_W-1:0] div_eff;
  logic [mcas_pkg::DIV_W-1:0] hi_len;
  logic [mcas_pkg::DIV_W-1:0] cnt_r;
  logic [mcas_pkg::DIV_W-1:0] cnt_nxt;
  logic [mcas_pkg::DLY_W-1:0] dly_r;
  logic wait_r;
  logic out_nxt;

  assign div_eff = (cfg.div < mcas_pkg::DIV_MIN) ? mcas_pkg::DIV_MIN : cfg.div;
  assign hi_len = div_eff >> 1;
  assign cnt_nxt = (cnt_r == div_eff - 8'h01) ? 8'h00 : cnt_r + 8'h01;
  assign out_nxt = cnt_nxt < hi_len;

  // Each high and low interval is whole: the counter only stops right after a
  // fall and only restarts at the start of a high interval.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
      clk_out <= 1'b0;
      frozen <= 1'b0;
      wait_r <= 1'b0;
      dly_r <= 12'h000;
    end else if (!frozen) begin
      cnt_r <= cnt_nxt;
      clk_out <= out_nxt;
      if (freeze_req && clk_out && !out_nxt) begin
        frozen <= 1'b1;
      end
    end else if (restart) begin
      wait_r <= 1'b1;
      dly_r <= eff_dly;
    end else if (wait_r) begin
      if (dly_r == 12'h000) begin
        wait_r <= 1'b0;
        frozen <= 1'b0;
        cnt_r <= 8'h00;
        clk_out <= 1'b1;
      end else begin
        dly_r <= dly_r - 12'h001;
      end
    end
  end

endmodule // mcas_out_div

`default_nettype wire

// [mcas_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// ------
// Checker
// ------
module mcas_chk #(
  parameter int N_OUT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request and bus
  input wire logic shared_align_request_pin,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Clock outputs
  input wire logic [N_OUT-1:0] clk_out
);
  logic ap_v, ap_w, sw, big;
  logic [7:0] ap_a;
  logic [9:0] hold;
  logic [N_OUT-1:0] en, prv, stuck;
  logic [7:0] cnt [N_OUT];
  wire logic req = shared_align_request_pin | sw;
  wire logic acc = hsel & htrans[1] & hready;
  wire logic [N_OUT-1:0] live = clk_out & en;
  // Shadow of the enables, so the checks know which outputs must freeze.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ap_v <= 1'b0;
      sw <= 1'b0;
      en <= '0;
      big <= 1'b0;
    end else begin
      ap_v <= acc;
      if (acc) begin
        ap_w <= hwrite;
        ap_a <= haddr[7:0];
      end
      if (ap_v && ap_w && ap_a == mcas_pkg::CTRL_OFS) begin
        sw <= hwdata[mcas_pkg::CTRL_SW_BIT];
      end
      for (int i = 0; i < N_OUT; i++) begin
        if (ap_v && ap_w && ap_a == mcas_pkg::OCFG_BASE_OFS + 8'(4 * i)) begin
          en[i] <= hwdata[mcas_pkg::OCFG_EN_BIT];
          big <= big | (hwdata[19:14] != 6'h00) | (hwdata[7:4] != 4'h0);
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || !req) hold <= '0;
    else if (hold != 10'h3FF) hold <= hold + 10'h001;
  end
  // A slow disabled output changes at least every 128 cycles.
  always_ff @(posedge clk) begin
    prv <= clk_out;
    for (int i = 0; i < N_OUT; i++) begin
      if (!rstn || clk_out[i] != prv[i]) cnt[i] <= 8'h00;
      else if (cnt[i] != 8'hFF) cnt[i] <= cnt[i] + 8'h01;
    end
  end
  always_comb begin
    for (int i = 0; i < N_OUT; i++) stuck[i] = cnt[i] > 8'hC8;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("Bus response not OKAY");
  property p_wait;
    acc |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Bus wait state wrong");
  property p_rdata;
    !(ap_v && !ap_w) |=> $stable(hrdata);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("Read data moved without a read");
  property p_start;
    $rose(req) |-> ##300 live == '0;
  endproperty
  a_start: assert property (p_start)
    else $error("Enabled outputs did not freeze");
  property p_held;
    hold >= 10'h258 |-> live == '0;
  endproperty
  a_held: assert property (p_held)
    else $error("Enabled output toggles while held");
  property p_keep;
    $fell(req) && hold >= 10'h258 |-> (live == '0) [*8];
  endproperty
  a_keep: assert property (p_keep)
    else $error("Output resumed too early");
  property p_resume;
    $fell(req) && hold >= 10'h258 && en != '0 && !big |-> ##[1:400] live != '0;
  endproperty
  a_resume: assert property (p_resume)
    else $error("Outputs did not resume");
  property p_free;
    (stuck & ~en) == '0;
  endproperty
  a_free: assert property (p_free)
    else $error("Disabled output stopped");
  c_seq: cover property ($fell(req) && hold >= 10'h258);
  c_read: cover property (acc && !hwrite);
  c_sw: cover property ($rose(sw));
endmodule // mcas_chk

bind mcas_top mcas_chk #(.N_OUT(N_OUT)) u_chk (
  .clk(clk), .rstn(rstn), .shared_align_request_pin(shared_align_request_pin),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .clk_out(clk_out)
);
`default_nettype wire

// [mcas_far.sv]
`timescale 1ns/1ns
`default_nettype none
// ------
// Sync source and trailing device
// ------
module mcas_far (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bench command
  input wire logic go,
  input wire logic arm,
  input wire logic [11:0] hold_cyc,
  // Link
  input wire logic clk_in,
  output logic sync_pin,
  output logic [7:0] seen
);
  logic [11:0] left;
  logic [2:0] skip;
  logic prv;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_pin <= 1'b0;
      left <= '0;
    end else if (go && !sync_pin) begin
      sync_pin <= 1'b1;
      left <= hold_cyc;
    end else if (left != '0) begin
      left <= left - 12'h001;
    end else begin
      sync_pin <= 1'b0;
    end
  end
  // Edges are counted on the lead clock, so the input must stay at or below half its rate.
  always_ff @(posedge clk) begin
    prv <= clk_in;
    // A software request reaches this device as its own arm command.
    if (!rstn || sync_pin || arm) begin
      skip <= 3'h7;
      seen <= 8'h00;
    end else if (clk_in && !prv) begin
      if (skip != 3'h0) skip <= skip - 3'h1;
      else if (seen != 8'hFF) seen <= seen + 8'h01;
    end
  end
endmodule // mcas_far
`default_nettype wire

// [mcas_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
// ------
// Bench
// ------
module mcas_tb_top;
  logic clk, rstn, hsel, hwrite, go, arm, mon, hreadyout, hresp, pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] clk_out, prv;
  logic [7:0] rnd, seen;
  logic [11:0] hold_cyc;
  logic [31:0] haddr, hwdata, hrdata, rdat, cyc, e;
  logic [31:0] rise_t [4];
  logic [31:0] fall_t [4];
  int mismatches, compares, mx;
  int dv [3];
  int dl [3];
  mcas_top dut (.clk(clk), .rstn(rstn), .shared_align_request_pin(pin), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .clk_out(clk_out));
  mcas_far u_far (.clk(clk), .rstn(rstn), .go(go), .arm(arm), .hold_cyc(hold_cyc),
    .clk_in(clk_out[0]), .sync_pin(pin), .seen(seen));
  always #5 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic int want(input int i, input int k);
    if (k == 0) return dl[i];
    return (i != 1) ? 7 * (mx - dv[i]) : 7 * mx;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    prv <= clk_out;
    for (int i = 0; i < 4; i++) begin
      if (!mon) rise_t[i] <= 32'h0;
      else if (clk_out[i] && !prv[i] && rise_t[i] == 32'h0) rise_t[i] <= cyc;
      if (!mon) fall_t[i] <= 32'h0;
      else if (!clk_out[i] && prv[i] && rise_t[i] != 32'h0 && fall_t[i] == 32'h0) fall_t[i] <= cyc;
    end
  end
  initial begin
    repeat (10000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    go = 1'b0;
    arm = 1'b0;
    mon = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    cyc = 32'h1;
    hold_cyc = 12'h2BC;
    rnd = 8'h3A;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, mcas_pkg::CTRL_OFS, 32'h0);
    chk(rdat, 32'h00000000);
    bus(1'b0, mcas_pkg::OCFG_BASE_OFS, 32'h0);
    chk(rdat, {24'h000000, mcas_pkg::DIV_RST});
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h00000000);
    $display("test registers done");
    // Pass 0 uses the pin and manual delays, passes 1 and 2 the software bit and auto
    // delays, and pass 2 runs the block in the trailing role.
    for (int k = 0; k < 3; k++) begin
      mx = 0;
      for (int i = 0; i < 3; i++) begin
        rnd = lfsr(rnd);
        dv[i] = 2 + rnd[2:0];
        rnd = lfsr(rnd);
        dl[i] = rnd[3:0];
        if (i != 1 && dv[i] > mx) mx = dv[i];
        e = {6'h00, i != 1, 1'b1, 4'h0, 12'(dl[i]), 8'(dv[i])};
        bus(1'b1, mcas_pkg::OCFG_BASE_OFS + 8'(4 * i), e);
        bus(1'b0, mcas_pkg::OCFG_BASE_OFS + 8'(4 * i), 32'h0);
        chk(rdat, e);
      end
      if (k == 0) begin
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
      end else begin
        arm <= 1'b1;
        bus(1'b1, mcas_pkg::CTRL_OFS, (k == 2) ? 32'h00000007 : 32'h00000005);
      end
      repeat (650) @(posedge clk);
      bus(1'b0, mcas_pkg::STAT_OFS, 32'h0);
      chk({20'h00000, rdat[11:0]}, 32'h0000070A);
      mon <= 1'b1;
      if (k != 0) begin
        arm <= 1'b0;
        bus(1'b1, mcas_pkg::CTRL_OFS, (k == 2) ? 32'h00000006 : 32'h00000004);
        bus(1'b0, mcas_pkg::CTRL_OFS, 32'h0);
        chk(rdat, (k == 2) ? 32'h00000006 : 32'h00000004);
      end
      do bus(1'b0, mcas_pkg::STAT_OFS, 32'h0); while (rdat[2:0] !== 3'h0);
      repeat (300) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
        chk(rise_t[i] - rise_t[0], 32'(want(i, k) - want(0, k)));
        chk(fall_t[i] - rise_t[i], 32'(dv[i] / 2));
      end
      chk(32'(seen != 8'h00), 32'h1);
      mon <= 1'b0;
      $display("test sync pass %0d done", k);
    end
    summarize();
  end
endmodule // mcas_tb_top
`default_nettype wire
